// File: logic/pstc_top.sv
// status and terminal-control register bank of a digital potentiometer
`timescale 1ns/1ns
// Contract
// R1: status nine bits, top ones, write-active bit
// R2: during nv write only volatile addresses
// R3: net1 lock blocks wiper1 and its controls
// R4: net0 lock blocks wiper0 and its controls
// R5: lock bits mirror nv lock, reload
// R6: lock and protect bits not register-writable
// R7: protect bit is pin OR nv bit
// R8: protection rejects all non-volatile writes
// R9: protection never blocks volatile writes
// R10: nine-bit terminal control layout
// R11: control applies after command completes
// R12: reset loads all ones
// R13: host rewrites control after device reset
// R14: general call accepted only when enabled
// R15: cleared release bit forces shutdown
// R16: connect bits switch their terminals
// R17: control changes leave wipers alone
// R18: 7/8-bit resolution, one or two networks
// R19: shutdown ignores but keeps connect bits
// R20: shutdown opens A, ties W to B
// R21: status writes change nothing
module pstc_top #(
  parameter int WIPER_BITS = 8,
  parameter int NUM_NETS = 2
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [3:0] CMD_ADDR,
  input wire logic CMD_WRITE,
  input wire logic [8:0] CMD_WDATA,
  input wire logic CMD_DONE,
  input wire logic NV_WRITE_BUSY,
  input wire logic NV_LOCK0,
  input wire logic NV_LOCK1,
  input wire logic NV_PROTECT,
  input wire logic WP_PIN,
  input wire logic GC_SEEN,
  output logic CMD_ALLOWED,
  output logic CMD_WRITE_OK,
  output logic [8:0] RDATA,
  output logic GC_ACCEPT,
  output logic [1:0] TERM_A_ON,
  output logic [1:0] TERM_W_ON,
  output logic [1:0] TERM_B_ON,
  output logic [1:0] W_TO_B,
  output logic WIPER_RES_8BIT
);
  // elaboration check on configuration
  if (!(WIPER_BITS == 7 || WIPER_BITS == 8) || !(NUM_NETS == 1 || NUM_NETS == 2))
  begin : g_bad_cfg
    $error("unsupported wiper width or network count");
  end

  typedef struct packed {
    logic [8:0] tc_shadow; // written value awaiting command end
    logic pend;
    logic [8:0] tc_live;   // value driving the switches
    logic [3:0] status;
    logic [8:0] rdata;
  } pstc_state_s;

  pstc_state_s st_q;
  pstc_state_s st_d;
  logic allowed;
  logic write_ok;
  logic lock0;
  logic lock1;
  logic protect;
  logic [8:0] tc_mask;
  logic [8:0] tc_view;

  // single-network builds hold net 1 permanently locked
  assign lock0 = st_q.status[pstc_pkg::ST_NET0_LOCK_BIT];
  assign lock1 = st_q.status[pstc_pkg::ST_NET1_LOCK_BIT] || (NUM_NETS == 1); // R18
  assign protect = st_q.status[pstc_pkg::ST_WP_BIT];

  pstc_access u_access (
    .addr(CMD_ADDR),
    .nv_write_active(st_q.status[pstc_pkg::ST_NV_ACTIVE_BIT]),
    .net0_lock(lock0),
    .net1_lock(lock1),
    .protect(protect),
    .allowed(allowed),
    .write_ok(write_ok)
  );

  // locked nibbles are masked out of terminal-control writes
  always_comb
  begin
    tc_mask = 9'h1FF;
    if (lock0)
      tc_mask[pstc_pkg::TC_NET_W-1:0] = 4'h0; // R4
    if (lock1)
      tc_mask[2*pstc_pkg::TC_NET_W-1:pstc_pkg::TC_NET_W] = 4'h0; // R3
  end

  // next-state logic
  always_comb
  begin
    st_d = st_q;
    // status mirrors system state only; no write path reaches it
    st_d.status[pstc_pkg::ST_NV_ACTIVE_BIT] = NV_WRITE_BUSY; // R1
    st_d.status[pstc_pkg::ST_NET1_LOCK_BIT] = NV_LOCK1; // R5 R6
    st_d.status[pstc_pkg::ST_NET0_LOCK_BIT] = NV_LOCK0; // R5 R6
    st_d.status[pstc_pkg::ST_WP_BIT] = WP_PIN | NV_PROTECT; // R7
    // switches follow only once the command has finished
    if (CMD_DONE && st_q.pend)
    begin
      st_d.tc_live = st_q.tc_shadow; // R11
      st_d.pend = 1'b0;
    end
    // a write in the same cycle as the command end stays pending; the set wins
    if (CMD_WRITE && allowed && CMD_ADDR == pstc_pkg::ADDR_TERM_CTRL)
    begin
      st_d.tc_shadow = (CMD_WDATA & tc_mask) | (st_q.tc_shadow & ~tc_mask); // R10
      st_d.pend = 1'b1;
    end
    // read data registered; control reads see the written shadow value, pending or committed
    unique case (CMD_ADDR)
      pstc_pkg::ADDR_TERM_CTRL: st_d.rdata = st_q.tc_shadow;
      pstc_pkg::ADDR_STATUS: st_d.rdata = {pstc_pkg::ST_RESERVED_ONES, st_q.status}; // R1
      default: st_d.rdata = 9'h000;
    endcase
  end

  // state register; status resets with write-active clear and locks open
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q.tc_shadow <= pstc_pkg::TC_RESET; // R12
      st_q.tc_live <= pstc_pkg::TC_RESET; // R12
      st_q.pend <= 1'b0;
      st_q.status <= 4'h0;
      st_q.rdata <= 9'h000;
    end
    else
      st_q <= st_d;
  end

  assign CMD_ALLOWED = allowed;
  assign CMD_WRITE_OK = write_ok && !(CMD_ADDR == pstc_pkg::ADDR_TERM_CTRL && lock0 && lock1);
  assign RDATA = st_q.rdata;
  assign GC_ACCEPT = GC_SEEN && st_q.tc_live[pstc_pkg::TC_GC_BIT]; // R14
  assign WIPER_RES_8BIT = (WIPER_BITS == 8); // R18
  // wiper registers live elsewhere and are never driven from here
  assign tc_view = st_q.tc_live; // R17

  // one switch decoder per network slot; both slots are built whatever NUM_NETS
  for (genvar n = 0; n < 2; n++)
  begin : g_net
    logic a;
    logic w;
    logic b;
    logic s;
    pstc_net_switch u_sw (
      .ctrl(tc_view[n*pstc_pkg::TC_NET_W +: pstc_pkg::TC_NET_W]),
      .a_on(a),
      .w_on(w),
      .b_on(b),
      .w_to_b(s)
    );
    assign TERM_A_ON[n] = a && (n < NUM_NETS);
    assign TERM_W_ON[n] = w && (n < NUM_NETS);
    assign TERM_B_ON[n] = b && (n < NUM_NETS);
    assign W_TO_B[n] = s && (n < NUM_NETS);
  end

  // checks
  sequence s_tc_write;
    CMD_WRITE && CMD_ALLOWED && CMD_ADDR == pstc_pkg::ADDR_TERM_CTRL;
  endsequence
  property p_status_read;
    @(posedge CLOCK) disable iff (!RST_B)
      CMD_ADDR == pstc_pkg::ADDR_STATUS |=> RDATA[8:4] == pstc_pkg::ST_RESERVED_ONES;
  endproperty
  a_status_read: assert property (p_status_read) else $error("reserved status bits not one"); // R1
  property p_nv_refuse;
    @(posedge CLOCK) disable iff (!RST_B)
      st_q.status[pstc_pkg::ST_NV_ACTIVE_BIT] && CMD_ADDR > pstc_pkg::ADDR_STATUS
      |-> !CMD_ALLOWED;
  endproperty
  a_nv_refuse: assert property (p_nv_refuse) else $error("access during nv write"); // R2
  property p_lock1;
    @(posedge CLOCK) disable iff (!RST_B)
      lock1 ##0 s_tc_write |=> $stable(st_q.tc_shadow[7:4]);
  endproperty
  a_lock1: assert property (p_lock1) else $error("locked net1 control changed"); // R3
  property p_lock0;
    @(posedge CLOCK) disable iff (!RST_B)
      lock0 ##0 s_tc_write |=> $stable(st_q.tc_shadow[3:0]);
  endproperty
  a_lock0: assert property (p_lock0) else $error("locked net0 control changed"); // R4
  property p_wp;
    @(posedge CLOCK) disable iff (!RST_B)
      (WP_PIN || NV_PROTECT) |=> st_q.status[0];
  endproperty
  a_wp: assert property (p_wp) else $error("protect status not set"); // R7
  property p_protect;
    @(posedge CLOCK) disable iff (!RST_B)
      protect && CMD_ADDR >= 4'h6 |-> !CMD_WRITE_OK;
  endproperty
  a_protect: assert property (p_protect) else $error("nv write under protect"); // R8
  property p_commit;
    @(posedge CLOCK) disable iff (!RST_B)
      CMD_DONE && st_q.pend |=> st_q.tc_live == $past(st_q.tc_shadow);
  endproperty
  a_commit: assert property (p_commit) else $error("control not applied at command end"); // R11
  property p_hold;
    @(posedge CLOCK) disable iff (!RST_B)
      !CMD_DONE |=> $stable(st_q.tc_live);
  endproperty
  a_hold: assert property (p_hold) else $error("control applied mid-command"); // R11
  property p_shdn;
    @(posedge CLOCK) disable iff (!RST_B)
      !st_q.tc_live[3] |-> !TERM_A_ON[0] && W_TO_B[0];
  endproperty
  a_shdn: assert property (p_shdn) else $error("net0 shutdown not forced"); // R20
  property p_gc;
    @(posedge CLOCK) disable iff (!RST_B)
      !st_q.tc_live[8] |-> !GC_ACCEPT;
  endproperty
  a_gc: assert property (p_gc) else $error("general call accepted while off"); // R14
  // status bits follow their sources one edge later
  property p_nv_flag;
    @(posedge CLOCK) disable iff (!RST_B)
      NV_WRITE_BUSY |=> st_q.status[pstc_pkg::ST_NV_ACTIVE_BIT];
  endproperty
  a_nv_flag: assert property (p_nv_flag) else $error("write-active flag missing"); // R1
  property p_lock_mirror;
    @(posedge CLOCK) disable iff (!RST_B)
      1'b1 |=> st_q.status[pstc_pkg::ST_NET1_LOCK_BIT] == $past(NV_LOCK1)
        && st_q.status[pstc_pkg::ST_NET0_LOCK_BIT] == $past(NV_LOCK0);
  endproperty
  a_lock_mirror: assert property (p_lock_mirror) else $error("lock status not mirrored"); // R5
  // wiper locations refuse writes while their network is locked
  property p_wiper0_lock;
    @(posedge CLOCK) disable iff (!RST_B)
      lock0 && (CMD_ADDR == pstc_pkg::ADDR_VWIPER0 || CMD_ADDR == pstc_pkg::ADDR_NVWIPER0)
      |-> !CMD_WRITE_OK;
  endproperty
  a_wiper0_lock: assert property (p_wiper0_lock) else $error("locked wiper0 writable"); // R4
  property p_wiper1_lock;
    @(posedge CLOCK) disable iff (!RST_B)
      lock1 && (CMD_ADDR == pstc_pkg::ADDR_VWIPER1 || CMD_ADDR == pstc_pkg::ADDR_NVWIPER1)
      |-> !CMD_WRITE_OK;
  endproperty
  a_wiper1_lock: assert property (p_wiper1_lock) else $error("locked wiper1 writable"); // R3
  // protection must never close the volatile wiper
  property p_vol_open;
    @(posedge CLOCK) disable iff (!RST_B)
      !lock0 && CMD_ADDR == pstc_pkg::ADDR_VWIPER0 |-> CMD_WRITE_OK;
  endproperty
  a_vol_open: assert property (p_vol_open) else $error("volatile wiper blocked"); // R9
  property p_status_ro;
    @(posedge CLOCK) disable iff (!RST_B)
      CMD_ADDR == pstc_pkg::ADDR_STATUS |-> !CMD_WRITE_OK;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status reported writable"); // R21
  // two steps: a write leaves the value pending until the command end
  sequence s_commit;
    CMD_DONE && st_q.pend;
  endsequence
  property p_pend_set;
    @(posedge CLOCK) disable iff (!RST_B)
      s_tc_write |=> st_q.pend;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("write not held pending"); // R11
  property p_pend_clear;
    @(posedge CLOCK) disable iff (!RST_B)
      s_commit ##0 !s_tc_write |=> !st_q.pend;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending write not cleared"); // R11
  // released network follows its connect bits
  property p_release0;
    @(posedge CLOCK) disable iff (!RST_B)
      st_q.tc_live[pstc_pkg::TC_SHDN_REL_BIT] |-> TERM_A_ON[0] == st_q.tc_live[pstc_pkg::TC_A_BIT]
        && TERM_W_ON[0] == st_q.tc_live[pstc_pkg::TC_W_BIT]
        && TERM_B_ON[0] == st_q.tc_live[pstc_pkg::TC_B_BIT] && !W_TO_B[0];
  endproperty
  a_release0: assert property (p_release0) else $error("net0 switches ignore bits"); // R16
  property p_shdn_ignore0;
    @(posedge CLOCK) disable iff (!RST_B)
      !st_q.tc_live[pstc_pkg::TC_SHDN_REL_BIT] |-> !TERM_W_ON[0] && !TERM_B_ON[0];
  endproperty
  a_shdn_ignore0: assert property (p_shdn_ignore0) else $error("net0 bits used in shutdown"); // R19
  property p_shdn1;
    @(posedge CLOCK) disable iff (!RST_B)
      NUM_NETS == 2 && !st_q.tc_live[pstc_pkg::TC_NET_W + pstc_pkg::TC_SHDN_REL_BIT]
      |-> !TERM_A_ON[1] && W_TO_B[1];
  endproperty
  a_shdn1: assert property (p_shdn1) else $error("net1 shutdown not forced"); // R15
  property p_gc_on;
    @(posedge CLOCK) disable iff (!RST_B)
      st_q.tc_live[pstc_pkg::TC_GC_BIT] && GC_SEEN |-> GC_ACCEPT;
  endproperty
  a_gc_on: assert property (p_gc_on) else $error("general call refused while on"); // R14
  // a single-network build never drives net1 switches
  property p_single_net;
    @(posedge CLOCK) disable iff (!RST_B)
      NUM_NETS == 1 |-> !TERM_A_ON[1] && !TERM_W_ON[1] && !TERM_B_ON[1] && !W_TO_B[1];
  endproperty
  a_single_net: assert property (p_single_net) else $error("absent net1 driven"); // R18
  // protect status clears one edge after both of its sources drop
  property p_status_wp_clear;
    @(posedge CLOCK) disable iff (!RST_B)
      !WP_PIN && !NV_PROTECT |=> !st_q.status[pstc_pkg::ST_WP_BIT];
  endproperty
  a_status_wp_clear: assert property (p_status_wp_clear) else $error("protect stuck"); // R7
endmodule : pstc_top

// File: logic/pstc_pkg.sv
// package of register map, field positions and reset values for the status/terminal-control bank
package pstc_pkg;
  // memory map addresses
  localparam logic [3:0] ADDR_VWIPER0 = 4'h0;
  localparam logic [3:0] ADDR_VWIPER1 = 4'h1;
  localparam logic [3:0] ADDR_NVWIPER0 = 4'h2;
  localparam logic [3:0] ADDR_NVWIPER1 = 4'h3;
  localparam logic [3:0] ADDR_TERM_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam int REG_W = 9;
  // status field positions
  localparam int ST_WP_BIT = 0;
  localparam int ST_NET0_LOCK_BIT = 1;
  localparam int ST_NET1_LOCK_BIT = 2;
  localparam int ST_NV_ACTIVE_BIT = 3;
  localparam logic [4:0] ST_RESERVED_ONES = 5'h1F;
  // terminal control field positions within one network nibble
  localparam int TC_B_BIT = 0;
  localparam int TC_W_BIT = 1;
  localparam int TC_A_BIT = 2;
  localparam int TC_SHDN_REL_BIT = 3;
  localparam int TC_NET_W = 4;
  localparam int TC_GC_BIT = 8;
  localparam logic [8:0] TC_RESET = 9'h1FF;
endpackage : pstc_pkg

// File: logic/pstc_access.sv
// access gate: decides whether a serial command may act on a location
`timescale 1ns/1ns
module pstc_access (
  input wire logic [3:0] addr,
  input wire logic nv_write_active,
  input wire logic net0_lock,
  input wire logic net1_lock,
  input wire logic protect,
  output logic allowed,
  output logic write_ok
);
  logic volatile_loc;
  // volatile locations stay reachable during a non-volatile write cycle
  always_comb
  begin
    volatile_loc = (addr == pstc_pkg::ADDR_VWIPER0) || (addr == pstc_pkg::ADDR_VWIPER1)
      || (addr == pstc_pkg::ADDR_TERM_CTRL) || (addr == pstc_pkg::ADDR_STATUS);
    allowed = volatile_loc || !nv_write_active; // R2
    write_ok = allowed;
    // wiper locks cover volatile and non-volatile copies
    if ((addr == pstc_pkg::ADDR_VWIPER0) || (addr == pstc_pkg::ADDR_NVWIPER0))
      write_ok = allowed && !net0_lock; // R4
    if ((addr == pstc_pkg::ADDR_VWIPER1) || (addr == pstc_pkg::ADDR_NVWIPER1))
      write_ok = allowed && !net1_lock; // R3
    // protection only touches non-volatile space, never volatile registers
    if (!volatile_loc && protect)
      write_ok = 1'b0; // R8 R9
    if (addr == pstc_pkg::ADDR_STATUS)
      write_ok = 1'b0; // R21
  end
endmodule : pstc_access

// File: logic/pstc_net_switch.sv
// per-network terminal switch decode with forced shutdown
`timescale 1ns/1ns
module pstc_net_switch (
  input wire logic [3:0] ctrl,
  output logic a_on,
  output logic w_on,
  output logic b_on,
  output logic w_to_b
);
  // shutdown overrides the connect bits without touching them
  always_comb
  begin
    if (!ctrl[pstc_pkg::TC_SHDN_REL_BIT])
    begin
      a_on = 1'b0; // R15 R20
      w_on = 1'b0; // R19
      b_on = 1'b0;
      w_to_b = 1'b1; // R20
    end
    else
    begin
      a_on = ctrl[pstc_pkg::TC_A_BIT]; // R16
      w_on = ctrl[pstc_pkg::TC_W_BIT];
      b_on = ctrl[pstc_pkg::TC_B_BIT];
      w_to_b = 1'b0;
    end
  end
endmodule : pstc_net_switch

// File: tb/pstc_host.sv
// host controller model that issues serial register commands
`timescale 1ns/1ns
module pstc_host (
  input wire logic clk,
  output logic [3:0] addr,
  output logic wr_en,
  output logic [8:0] wdata,
  output logic done
);
  initial
  begin
    addr = 4'h0;
    wr_en = 1'b0;
    wdata = 9'h000;
    done = 1'b0;
  end
  // point the command at a location; held until the next command
  task automatic select(input logic [3:0] a);
    addr = a;
  endtask : select
  // one-cycle write strobe; data no longer meaningful after it
  task automatic write_cmd(input logic [3:0] a, input logic [8:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    wdata = ~d; // stale data is not left on the bus
  endtask : write_cmd
  // stop condition: ends the command and commits it
  task automatic finish_cmd();
    @(posedge clk);
    #1;
    done = 1'b1;
    @(posedge clk);
    #1;
    done = 1'b0;
  endtask : finish_cmd
endmodule : pstc_host

// File: tb/tb.sv
// self-checking bench for the status and terminal-control bank
`timescale 1ns/1ns
module tb;
  logic clock, rst_b, busy, lock0, lock1, prot, wp, gc_seen;
  logic [3:0] addr;
  logic wr_en, done, allowed, write_ok, gc_acc, res8;
  logic [8:0] wdata, rdata, v;
  logic [1:0] a_on, w_on, b_on, w_to_b;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [8:0] tbl [3] = '{9'h0F7, 9'h07A, 9'h1FF};
  logic [3:0] vol [4] = '{4'h0, 4'h1, 4'h4, 4'h5};
  pstc_host pstc_host_i (.clk(clock), .addr(addr), .wr_en(wr_en), .wdata(wdata), .done(done));
  pstc_top pstc_top_i (.CLOCK(clock), .RST_B(rst_b), .CMD_ADDR(addr), .CMD_WRITE(wr_en),
    .CMD_WDATA(wdata), .CMD_DONE(done), .NV_WRITE_BUSY(busy), .NV_LOCK0(lock0),
    .NV_LOCK1(lock1), .NV_PROTECT(prot), .WP_PIN(wp), .GC_SEEN(gc_seen),
    .CMD_ALLOWED(allowed), .CMD_WRITE_OK(write_ok), .RDATA(rdata), .GC_ACCEPT(gc_acc),
    .TERM_A_ON(a_on), .TERM_W_ON(w_on), .TERM_B_ON(b_on), .W_TO_B(w_to_b),
    .WIPER_RES_8BIT(res8));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard: the tests need well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk_word(input string name, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %0s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word
  task automatic chk_flag(input string name, input logic exp, input logic got);
    chk_word(name, {8'h00, exp}, {8'h00, got});
  endtask : chk_flag
  // status sampling plus registered read data: two edges to settle, three waited
  task automatic rd(input logic [3:0] a, input logic [8:0] exp, input string name);
    pstc_host_i.select(a);
    repeat (3) @(posedge clock);
    #1;
    chk_word(name, exp, rdata);
  endtask : rd
  // shutdown opens A and ties W to B; connect bits only matter when released
  task automatic chk_net(input int n, input logic [3:0] nib);
    chk_flag("a_on", nib[3] & nib[2], a_on[n]);
    chk_flag("w_to_b", ~nib[3], w_to_b[n]);
    if (nib[3])
    begin
      chk_flag("w_on", nib[1], w_on[n]);
      chk_flag("b_on", nib[0], b_on[n]);
    end
  endtask : chk_net
  initial
  begin
    {busy, lock0, lock1, prot, wp} = 5'h00;
    gc_seen = 1'b1;
    rst_b = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    rst_b = 1'b1;
    rd(4'h4, 9'h1FF, "tc reset");
    chk_net(0, 4'hF);
    chk_net(1, 4'hF);
    chk_flag("gc", 1'b1, gc_acc);
    chk_flag("res8", 1'b1, res8);
    rd(4'h5, 9'h1F0, "status reset");
    $display("test reset done");
    foreach (tbl[i])
    begin
      v = (i == 0) ? 9'h1FF : tbl[i - 1];
      pstc_host_i.write_cmd(4'h4, tbl[i]);
      rd(4'h4, tbl[i], "tc readback");
      chk_net(0, v[3:0]);
      pstc_host_i.finish_cmd();
      chk_net(0, tbl[i][3:0]);
      chk_net(1, tbl[i][7:4]);
      chk_flag("gc", tbl[i][8], gc_acc);
    end
    $display("test terminal control done");
    lock1 = 1'b1;
    rd(4'h5, 9'h1F4, "status lock1");
    pstc_host_i.select(4'h1);
    #1;
    chk_flag("wiper1 write_ok", 1'b0, write_ok);
    pstc_host_i.write_cmd(4'h4, 9'h000);
    pstc_host_i.finish_cmd();
    rd(4'h4, 9'h0F0, "tc lock1");
    {lock1, lock0} = 2'b01;
    rd(4'h5, 9'h1F2, "status lock0");
    pstc_host_i.select(4'h2);
    #1;
    chk_flag("wiper0 write_ok", 1'b0, write_ok);
    pstc_host_i.write_cmd(4'h4, 9'h1FF);
    pstc_host_i.finish_cmd();
    rd(4'h4, 9'h1F0, "tc lock0");
    lock0 = 1'b0;
    $display("test locks done");
    pstc_host_i.write_cmd(4'h5, 9'h000);
    chk_flag("status write_ok", 1'b0, write_ok);
    rd(4'h5, 9'h1F0, "status after write");
    wp = 1'b1;
    rd(4'h5, 9'h1F1, "status pin");
    pstc_host_i.select(4'h2);
    #1;
    chk_flag("nv write_ok", 1'b0, write_ok);
    pstc_host_i.select(4'h0);
    #1;
    chk_flag("vol write_ok", 1'b1, write_ok);
    {wp, prot} = 2'b01;
    rd(4'h5, 9'h1F1, "status nv bit");
    prot = 1'b0;
    $display("test protect done");
    busy = 1'b1;
    rd(4'h5, 9'h1F8, "status busy");
    pstc_host_i.select(4'h6);
    #1;
    chk_flag("busy allowed", 1'b0, allowed);
    foreach (vol[i])
    begin
      pstc_host_i.select(vol[i]);
      #1;
      chk_flag("vol allowed", 1'b1, allowed);
    end
    gc_seen = 1'b0;
    #1;
    chk_flag("gc idle", 1'b0, gc_acc);
    $display("test busy done");
    wrap_up();
  end
endmodule : tb
